// File: core/lpwc_pkg.sv
// Shared constants and types of the low-power mode and wake controller.
package lpwc_pkg;
  localparam int CLK_HZ         = 25_000_000;
  localparam int WD_HZ          = 32768;
  localparam int WD_DIV_CYC     = CLK_HZ / WD_HZ;
  localparam int PLL_SETTLE_US  = 100;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int CPU_RST_CYC    = 16;
  localparam int WD_WIDTH       = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN  = 8'h04;
  localparam logic [7:0] OFS_MODE_REQ = 8'h08;
  localparam logic [7:0] OFS_MAILBOX  = 8'h0c;
  localparam logic [7:0] OFS_WD_LOAD  = 8'h10;
  localparam logic [7:0] OFS_WD_KICK  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_WD_COUNT = 8'h1c;

  // Control register fields and the status expiry bit.
  localparam int CTRL_WD_EN      = 0;
  localparam int CTRL_WD_EXT_CLK = 1;
  localparam int CTRL_WD_IRQ_EN  = 2;
  localparam int CTRL_WD_WAKE_EN = 3;
  localparam int CTRL_WD_RST_EN  = 4;
  localparam int CTRL_CTS_POL    = 5;
  localparam int CTRL_W          = 6;
  localparam int STAT_WD_EXP     = 8;

  // Reset values.
  localparam logic [5:0]  CTRL_RST    = 6'h00;
  localparam logic [6:0]  WAKE_EN_RST = 7'h7f;
  localparam logic [15:0] WD_LOAD_RST = 16'hffff;

  // Power level codes used by requests and the level readback.
  localparam logic [2:0] LVL_NORMAL   = 3'h0;
  localparam logic [2:0] LVL_SUSP_ON  = 3'h1;
  localparam logic [2:0] LVL_SUSP_OFF = 3'h2;
  localparam logic [2:0] LVL_STANDBY  = 3'h3;
  localparam logic [2:0] LVL_CORE_OFF = 3'h4;
  localparam logic [2:0] LVL_RESTART  = 3'h7;

  // Pin indices: the first seven are wake sources and wake cause bits.
  localparam int P_DP       = 0;
  localparam int P_DM       = 1;
  localparam int P_ID       = 2;
  localparam int P_VBUS     = 3;
  localparam int P_SS_RX    = 4;
  localparam int P_CTS      = 5;
  localparam int P_PCTRL0   = 6;
  localparam int P_WDCLK    = 7;
  localparam int P_LOCK     = 8;
  localparam int NUM_WAKE   = 7;
  localparam int NUM_PINS   = 9;

  typedef enum logic [2:0] {ST_NORMAL, ST_SUSP_ON, ST_SUSP_OFF, ST_STANDBY, ST_RESTART} lpwc_state_t;
endpackage

// File: core/lpwc_pin_sync.sv
// Two-stage synchroniser bank with a change detector behind it.
`timescale 1ns/1ps
module lpwc_pin_sync #(
  parameter int N = 9
) (
  input  wire logic         clk,      // System clock.
  input  wire logic         rst_n,    // Asynchronous reset, active low.
  input  wire logic [N-1:0] pin_in,   // Asynchronous pin levels.
  output logic      [N-1:0] lvl,      // Synchronised levels.
  output logic      [N-1:0] chg       // One-cycle pulse on any change.
);
  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;
  logic [N-1:0] prev_ff;

  // The change detector looks only at the second and third stages.
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
        prev_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= pin_in[i];
        sync_ff[i] <= meta_ff[i];
        prev_ff[i] <= sync_ff[i];
      end
    end
    assign chg[i] = sync_ff[i] ^ prev_ff[i];
  end

  assign lvl = sync_ff;
endmodule

// File: core/lpwc_watchdog.sv
// Watchdog counter ticking at 32 kHz from an internal divider or an external clock pin.
`timescale 1ns/1ps
module lpwc_watchdog #(
  parameter int WIDTH = 16,
  parameter int DIV   = lpwc_pkg::WD_DIV_CYC
) (
  input  wire logic             clk,      // System clock.
  input  wire logic             rst_n,    // Asynchronous reset, active low.
  input  wire logic             enable,   // Watchdog runs while high.
  input  wire logic             ext_sel,  // Count on the external 32 kHz clock.
  input  wire logic             ext_lvl,  // Synchronised external clock level.
  input  wire logic [WIDTH-1:0] load_val, // Reload value.
  input  wire logic             kick,     // Reload pulse from firmware.
  output logic      [WIDTH-1:0] count,    // Current count.
  output logic                  expire    // One-cycle expiry pulse.
);
  localparam int DW = $clog2(DIV);
  logic [DW-1:0]    div_ff;
  logic             ext_d_ff;
  logic [WIDTH-1:0] cnt_ff;
  logic             exp_ff;
  logic             tick;

  // The external clock is sampled, so only its rising edges in this clock matter.
  assign tick = ext_sel ? (ext_lvl & ~ext_d_ff) : (div_ff == DW'(DIV - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff   <= '0;
      ext_d_ff <= 1'b0;
    end else begin
      ext_d_ff <= ext_lvl;
      div_ff   <= (div_ff == DW'(DIV - 1)) ? '0 : div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '1;
      exp_ff <= 1'b0;
    end else begin
      exp_ff <= 1'b0;
      if (!enable || kick) begin
        cnt_ff <= load_val;
      end else if (tick) begin
        if (cnt_ff == '0) begin
          cnt_ff <= load_val;
          exp_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end

  assign count  = cnt_ff;
  assign expire = exp_ff;
endmodule

// File: core/lpwc_ctrl.sv
// Power-level sequencer, wake logic, watchdog actions and register file.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module lpwc_ctrl (
  input  wire logic        CLOCK,                  // 25 MHz system clock.
  input  wire logic        RSTN,                   // Hard reset, asynchronous, active low.
  input  wire logic [7:0]  REG_ADDR,               // Register byte address.
  input  wire logic [31:0] REG_WDATA,              // Register write data.
  input  wire logic        REG_WR,                 // Write strobe.
  input  wire logic        REG_RD,                 // Read strobe.
  output logic      [31:0] REG_RDATA,              // Read data, valid the cycle after REG_RD.
  input  wire logic        MBX_WR,                 // Mailbox write strobe from the external processor.
  input  wire logic [7:0]  MBX_DATA,               // Mailbox data, low bits hold a level code.
  input  wire logic        USB_DP,                 // USB 2.0 D+ level.
  input  wire logic        USB_DM,                 // USB 2.0 D- level.
  input  wire logic        ID_PIN_SENSE,           // Identity pin impedance comparator.
  input  wire logic        VBUS_DET,               // Bus power detected.
  input  wire logic        SS_RECEIVE_PAIR_RESUME, // Resume seen on the SuperSpeed receive pair.
  input  wire logic        UART_CTS,               // Serial clear-to-send pin.
  input  wire logic        PARALLEL_CTRL_LINE0,    // Parallel interface control line zero.
  input  wire logic        WD_CLK_32K,             // Optional external 32 kHz clock.
  input  wire logic        PLL_LOCK,               // PLL lock indication.
  output logic             CPU_CLK_EN,             // Processor clock enable.
  output logic             PLL_EN,                 // PLL enable.
  output logic             SS_PHY_EN,              // SuperSpeed PHY enable.
  output logic             SS_PHY_U3,              // Hold the PHY in U3.
  output logic             IO_HOLD,                // Freeze all I/O pins.
  output logic             USB_STATE_HOLD,         // Freeze the USB interface state.
  output logic             RETAIN,                 // Keep RAM and buffers in retention.
  output logic             CPU_IRQ,                // Watchdog interrupt to the core.
  output logic             CPU_RESET_N,            // Core reset, active low.
  output logic      [2:0]  POWER_LEVEL             // Current power level code.
);
  localparam int SW = $clog2(lpwc_pkg::PLL_SETTLE_CYC + 1);
  localparam int RW = $clog2(lpwc_pkg::CPU_RST_CYC + 1);

  lpwc_pkg::lpwc_state_t state_ff, nxt_state;
  logic [lpwc_pkg::CTRL_W-1:0]   ctrl_ff;
  logic [lpwc_pkg::NUM_WAKE-1:0] wake_en_ff;
  logic [lpwc_pkg::NUM_WAKE-1:0] cause_ff;
  logic [15:0]                   wd_load_ff;
  logic [7:0]                    mbx_ff;
  logic                          wd_exp_ff;
  logic                          pc_rst_pend_ff;
  logic [SW-1:0]                 settle_ff;
  logic [RW-1:0]                 rst_cnt_ff;
  logic [6:0]                    out_ff;
  logic                          irq_ff;
  logic [31:0]                   rdata_ff;

  logic [lpwc_pkg::NUM_PINS-1:0] pin_lvl;
  logic [lpwc_pkg::NUM_PINS-1:0] pin_chg;
  logic [lpwc_pkg::NUM_WAKE-1:0] wake_hit;
  logic [lpwc_pkg::NUM_WAKE-1:0] wake_act;
  logic [15:0]                   wd_count;
  logic                          wd_expire;
  logic                          wd_wake;
  logic                          wake_go;
  logic                          normal;
  logic                          wr_ok;
  logic                          fw_req;
  logic [2:0]                    req_lvl;
  logic                          req_valid;

  // Wake sources a level listens to; standby keeps only the low-power detectors.
  function automatic logic [lpwc_pkg::NUM_WAKE-1:0] allowed(input lpwc_pkg::lpwc_state_t s);
    unique case (s)
      lpwc_pkg::ST_SUSP_ON:  allowed = '1;
      lpwc_pkg::ST_SUSP_OFF: allowed = ~(7'h01 << lpwc_pkg::P_SS_RX);
      lpwc_pkg::ST_STANDBY:  allowed = (7'h01 << lpwc_pkg::P_VBUS) | (7'h01 << lpwc_pkg::P_CTS)
                                       | (7'h01 << lpwc_pkg::P_PCTRL0);
      default:               allowed = '0;
    endcase
  endfunction

  // Output set per state: {cpu clk, pll, phy, u3, io hold, usb hold, retain}.
  function automatic logic [6:0] outs(input lpwc_pkg::lpwc_state_t s);
    unique case (s)
      lpwc_pkg::ST_NORMAL:   outs = 7'h70;
      lpwc_pkg::ST_SUSP_ON:  outs = 7'h1d;
      lpwc_pkg::ST_SUSP_OFF: outs = 7'h07;
      lpwc_pkg::ST_STANDBY:  outs = 7'h04;
      default:               outs = 7'h2f;
    endcase
  endfunction

  lpwc_pin_sync #(
    .N (lpwc_pkg::NUM_PINS)
  ) u_sync (
    .clk    (CLOCK),
    .rst_n  (RSTN),
    .pin_in ({PLL_LOCK, WD_CLK_32K, PARALLEL_CTRL_LINE0, UART_CTS, SS_RECEIVE_PAIR_RESUME,
              VBUS_DET, ID_PIN_SENSE, USB_DM, USB_DP}),
    .lvl    (pin_lvl),
    .chg    (pin_chg)
  );

  lpwc_watchdog #(
    .WIDTH (lpwc_pkg::WD_WIDTH)
  ) u_wd (
    .clk      (CLOCK),
    .rst_n    (RSTN),
    .enable   (ctrl_ff[lpwc_pkg::CTRL_WD_EN]),
    .ext_sel  (ctrl_ff[lpwc_pkg::CTRL_WD_EXT_CLK]),
    .ext_lvl  (pin_lvl[lpwc_pkg::P_WDCLK]),
    .load_val (wd_load_ff),
    .kick     (wr_ok && REG_ADDR == lpwc_pkg::OFS_WD_KICK),
    .count    (wd_count),
    .expire   (wd_expire)
  );

  assign normal = (state_ff == lpwc_pkg::ST_NORMAL);
  // Register writes only land while the core runs, so suspend leaves control, wake enable and reload untouched.
  assign wr_ok  = REG_WR && normal;

  assign wake_hit[lpwc_pkg::P_DP]     = pin_chg[lpwc_pkg::P_DP];
  assign wake_hit[lpwc_pkg::P_DM]     = pin_chg[lpwc_pkg::P_DM];
  assign wake_hit[lpwc_pkg::P_ID]     = pin_chg[lpwc_pkg::P_ID];
  assign wake_hit[lpwc_pkg::P_VBUS]   = pin_lvl[lpwc_pkg::P_VBUS];
  assign wake_hit[lpwc_pkg::P_SS_RX]  = pin_lvl[lpwc_pkg::P_SS_RX];
  assign wake_hit[lpwc_pkg::P_CTS]    = pin_lvl[lpwc_pkg::P_CTS] == ctrl_ff[lpwc_pkg::CTRL_CTS_POL];
  assign wake_hit[lpwc_pkg::P_PCTRL0] = pin_lvl[lpwc_pkg::P_PCTRL0];

  assign wake_act = wake_hit & wake_en_ff & allowed(state_ff);
  assign wd_wake  = (state_ff == lpwc_pkg::ST_STANDBY) && wd_expire
                    && ctrl_ff[lpwc_pkg::CTRL_WD_WAKE_EN];
  assign wake_go  = (|wake_act) || wd_wake;

  // Firmware requests win over a mailbox request in the same cycle.
  assign fw_req    = wr_ok && REG_ADDR == lpwc_pkg::OFS_MODE_REQ;
  assign req_lvl   = fw_req ? REG_WDATA[2:0] : MBX_DATA[2:0];
  // Core power-down is reached by removing supply, so that code is ignored here.
  assign req_valid = normal && (fw_req || MBX_WR) && req_lvl != lpwc_pkg::LVL_NORMAL
                     && req_lvl != lpwc_pkg::LVL_CORE_OFF && req_lvl <= lpwc_pkg::LVL_STANDBY;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      lpwc_pkg::ST_NORMAL: begin
        if (req_valid) begin
          unique case (req_lvl)
            lpwc_pkg::LVL_SUSP_ON:  nxt_state = lpwc_pkg::ST_SUSP_ON;
            lpwc_pkg::LVL_SUSP_OFF: nxt_state = lpwc_pkg::ST_SUSP_OFF;
            default:                nxt_state = lpwc_pkg::ST_STANDBY;
          endcase
        end
      end
      lpwc_pkg::ST_SUSP_ON, lpwc_pkg::ST_SUSP_OFF, lpwc_pkg::ST_STANDBY: begin
        if (wake_go) begin
          nxt_state = lpwc_pkg::ST_RESTART;
        end
      end
      lpwc_pkg::ST_RESTART: begin
        if (settle_ff == '0) begin
          nxt_state = lpwc_pkg::ST_NORMAL;
        end
      end
      default: nxt_state = lpwc_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= lpwc_pkg::ST_NORMAL;
      out_ff   <= 7'h70;
    end else begin
      state_ff <= nxt_state;
      out_ff   <= outs(nxt_state);
    end
  end

  // Lock must be seen for the whole settle time; a drop restarts the wait.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      settle_ff <= SW'(lpwc_pkg::PLL_SETTLE_CYC);
    end else if (state_ff != lpwc_pkg::ST_RESTART || !pin_lvl[lpwc_pkg::P_LOCK]) begin
      settle_ff <= SW'(lpwc_pkg::PLL_SETTLE_CYC);
    end else if (settle_ff != '0) begin
      settle_ff <= settle_ff - 1'b1;
    end
  end

  // Only a standby exit restarts the program; suspend resumes in place.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pc_rst_pend_ff <= 1'b0;
    end else if (state_ff == lpwc_pkg::ST_STANDBY && wake_go) begin
      pc_rst_pend_ff <= 1'b1;
    end else if (normal) begin
      pc_rst_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_cnt_ff <= '0;
    end else if ((normal && wd_expire && ctrl_ff[lpwc_pkg::CTRL_WD_RST_EN])
                 || (state_ff == lpwc_pkg::ST_RESTART && settle_ff == '0 && pc_rst_pend_ff)) begin
      rst_cnt_ff <= RW'(lpwc_pkg::CPU_RST_CYC);
    end else if (rst_cnt_ff != '0) begin
      rst_cnt_ff <= rst_cnt_ff - 1'b1;
    end
  end

  // Wake causes and expiry are sticky; a new event beats a clear in the same cycle.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cause_ff  <= '0;
      wd_exp_ff <= 1'b0;
    end else begin
      if (wr_ok && REG_ADDR == lpwc_pkg::OFS_STATUS) begin
        cause_ff  <= (cause_ff & ~REG_WDATA[lpwc_pkg::NUM_WAKE-1:0]) | wake_act;
        wd_exp_ff <= (wd_exp_ff & ~REG_WDATA[lpwc_pkg::STAT_WD_EXP]) | wd_expire;
      end else begin
        cause_ff  <= cause_ff | wake_act;
        wd_exp_ff <= wd_exp_ff | wd_expire;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= wd_exp_ff && ctrl_ff[lpwc_pkg::CTRL_WD_IRQ_EN] && ctrl_ff[lpwc_pkg::CTRL_WD_EN];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_ff    <= lpwc_pkg::CTRL_RST;
      wake_en_ff <= lpwc_pkg::WAKE_EN_RST;
      wd_load_ff <= lpwc_pkg::WD_LOAD_RST;
    end else if (wr_ok) begin
      unique case (REG_ADDR)
        lpwc_pkg::OFS_CTRL:    ctrl_ff    <= REG_WDATA[lpwc_pkg::CTRL_W-1:0];
        lpwc_pkg::OFS_WAKE_EN: wake_en_ff <= REG_WDATA[lpwc_pkg::NUM_WAKE-1:0];
        lpwc_pkg::OFS_WD_LOAD: wd_load_ff <= REG_WDATA[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mbx_ff <= '0;
    end else if (MBX_WR) begin
      mbx_ff <= MBX_DATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        lpwc_pkg::OFS_CTRL:     rdata_ff <= {26'h0, ctrl_ff};
        lpwc_pkg::OFS_WAKE_EN:  rdata_ff <= {25'h0, wake_en_ff};
        lpwc_pkg::OFS_MODE_REQ: rdata_ff <= {29'h0, POWER_LEVEL};
        lpwc_pkg::OFS_MAILBOX:  rdata_ff <= {24'h0, mbx_ff};
        lpwc_pkg::OFS_WD_LOAD:  rdata_ff <= {16'h0, wd_load_ff};
        lpwc_pkg::OFS_STATUS:   rdata_ff <= {23'h0, wd_exp_ff, 1'b0, cause_ff};
        lpwc_pkg::OFS_WD_COUNT: rdata_ff <= {16'h0, wd_count};
        default:                rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign REG_RDATA      = rdata_ff;
  assign {CPU_CLK_EN, PLL_EN, SS_PHY_EN, SS_PHY_U3, IO_HOLD, USB_STATE_HOLD, RETAIN} = out_ff;
  assign CPU_IRQ        = irq_ff;
  assign CPU_RESET_N    = (rst_cnt_ff == '0);
  assign POWER_LEVEL    = (state_ff == lpwc_pkg::ST_SUSP_ON)  ? lpwc_pkg::LVL_SUSP_ON  :
                          (state_ff == lpwc_pkg::ST_SUSP_OFF) ? lpwc_pkg::LVL_SUSP_OFF :
                          (state_ff == lpwc_pkg::ST_STANDBY)  ? lpwc_pkg::LVL_STANDBY  :
                          (state_ff == lpwc_pkg::ST_RESTART)  ? lpwc_pkg::LVL_RESTART  : lpwc_pkg::LVL_NORMAL;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  chk_wd_off_quiet: assert property (!ctrl_ff[0] |=> !wd_expire)
    else $error("watchdog expired while disabled");
  chk_normal_clocks: assert property (normal && $past(normal) |-> CPU_CLK_EN && PLL_EN)
    else $error("normal mode without processor clock or PLL");
  chk_phy_on_only: assert property (state_ff == lpwc_pkg::ST_SUSP_ON && $past(state_ff) == state_ff
    |-> SS_PHY_EN && SS_PHY_U3 && !CPU_CLK_EN && !PLL_EN)
    else $error("PHY-on suspend clocks wrong");
  chk_phy_off_all: assert property (state_ff == lpwc_pkg::ST_SUSP_OFF && $past(state_ff) == state_ff
    |-> !SS_PHY_EN && !PLL_EN && !CPU_CLK_EN && USB_STATE_HOLD)
    else $error("PHY-off suspend left something running");
  chk_io_hold_susp: assert property ((state_ff == lpwc_pkg::ST_SUSP_ON || state_ff == lpwc_pkg::ST_SUSP_OFF)
    ##1 (state_ff == lpwc_pkg::ST_SUSP_ON || state_ff == lpwc_pkg::ST_SUSP_OFF) |-> IO_HOLD && RETAIN)
    else $error("I/O not held in suspend");
  chk_cfg_frozen: assert property (!normal |=> $stable(ctrl_ff) && $stable(wake_en_ff))
    else $error("configuration changed in suspend");
  chk_no_pc_reset: assert property ($past(state_ff) == lpwc_pkg::ST_SUSP_OFF && state_ff == lpwc_pkg::ST_RESTART
    |-> !pc_rst_pend_ff)
    else $error("suspend wake scheduled a program reset");
  chk_fw_enters: assert property (fw_req && REG_WDATA[2:0] == lpwc_pkg::LVL_SUSP_ON
    |=> state_ff == lpwc_pkg::ST_SUSP_ON ##1 !CPU_CLK_EN)
    else $error("firmware suspend request not taken");
  chk_mbx_enters: assert property (normal && MBX_WR && !REG_WR && MBX_DATA[2:0] == lpwc_pkg::LVL_SUSP_OFF
    |=> state_ff == lpwc_pkg::ST_SUSP_OFF)
    else $error("mailbox suspend request not taken");
  chk_wake_exit: assert property (state_ff == lpwc_pkg::ST_SUSP_OFF && |wake_act |=> state_ff == lpwc_pkg::ST_RESTART)
    else $error("wake event ignored");
  chk_ss_rx_off: assert property (state_ff == lpwc_pkg::ST_SUSP_OFF |-> !wake_act[lpwc_pkg::P_SS_RX])
    else $error("receive pair woke PHY-off suspend");
  chk_settle_wait: assert property (state_ff == lpwc_pkg::ST_RESTART && settle_ff != '0 |=> !normal)
    else $error("resumed before PLL settled");
  chk_wd_core_rst: assert property (normal && wd_expire && ctrl_ff[4] |=> !CPU_RESET_N [*8])
    else $error("watchdog reset too short");

  cov_phy_on_wake: cover property (state_ff == lpwc_pkg::ST_SUSP_ON ##1 state_ff == lpwc_pkg::ST_RESTART);
  cov_phy_off_wake: cover property (state_ff == lpwc_pkg::ST_SUSP_OFF ##1 state_ff == lpwc_pkg::ST_RESTART);
  cov_standby_wd: cover property (wd_wake);
endmodule

// File: test/lpwc_host_model.sv
// Model of the external requesting processor and of the PLL behind the power controller.
`timescale 1ns/1ps
module lpwc_host_model (
  input  wire logic       clk,      // System clock.
  input  wire logic       req,      // Ask for a level through the mailbox.
  input  wire logic [2:0] lvl,      // Level code to ask for.
  input  wire logic       pll_en,   // PLL enable from the controller.
  output logic            mbx_wr,   // Mailbox strobe.
  output logic      [7:0] mbx_data, // Mailbox data.
  output logic            lock      // PLL lock.
);
  int lk = 0;
  // The bench raises req only once its own traffic has drained.
  always @(posedge clk) begin
    mbx_wr <= req;
    mbx_data <= {5'h00, lvl};
  end
  // Lock lags the enable by 22 cycles, so the settle count cannot start early.
  always @(posedge clk) begin
    lk <= pll_en ? lk + 1 : 0;
    lock <= lk > 20;
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench of the power-level controller.
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, req = 0, wdck = 0, mw, lock;
  logic [7:0] addr = 8'h00, md;
  logic [31:0] wdata = 32'h0, rdata;
  logic [6:0] pin = 7'h20;
  logic [2:0] rl = 3'h0, pl, lv;
  logic cen, pen, phy, u3, ioh, usbh, ret, irq, crn;
  wire [6:0] outs = {cen, pen, phy, u3, ioh, usbh, ret};
  int miscompares = 0, check_count = 0, cyc = 0;
  lpwc_ctrl lpwc_ctrl_inst (.CLOCK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .MBX_WR(mw), .MBX_DATA(md), .USB_DP(pin[0]), .USB_DM(pin[1]),
    .ID_PIN_SENSE(pin[2]), .VBUS_DET(pin[3]), .SS_RECEIVE_PAIR_RESUME(pin[4]), .UART_CTS(pin[5]),
    .PARALLEL_CTRL_LINE0(pin[6]), .WD_CLK_32K(wdck), .PLL_LOCK(lock), .CPU_CLK_EN(cen), .PLL_EN(pen),
    .SS_PHY_EN(phy), .SS_PHY_U3(u3), .IO_HOLD(ioh), .USB_STATE_HOLD(usbh), .RETAIN(ret), .CPU_IRQ(irq),
    .CPU_RESET_N(crn), .POWER_LEVEL(pl));
  lpwc_host_model lpwc_host_model_inst (.clk(clk), .req(req), .lvl(rl), .pll_en(pen), .mbx_wr(mw),
    .mbx_data(md), .lock(lock));
  initial forever #20 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The external watchdog clock runs far above 32 kHz to keep the run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 0) wdck <= ~wdck;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); chk(n, rdata, e);
  endtask
  task automatic wait_on(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge clk);
  endtask
  task automatic wait_pl(logic [2:0] e, int n);
    for (int i = 0; i < n && pl !== e; i++) @(negedge clk);
    chk("level", pl, e);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rreg(8'h00, 32'h0, "ctrl");
    rreg(8'h04, 32'h7f, "wake_en");
    rreg(8'h10, 32'hffff, "wd_load");
    rreg(8'h1c, 32'hffff, "wd_count");
    rreg(8'h20, 32'h0, "unmapped");
    chk("outs", outs, 7'h70);
    // Every wake source in turn, alternating firmware and mailbox requests.
    for (int s = 0; s < 7; s++) begin
      lv = (s == 4) ? lpwc_pkg::LVL_SUSP_ON : lpwc_pkg::LVL_SUSP_OFF;
      if (s % 2 == 1) begin
        @(posedge clk); rl <= lv; req <= 1'b1;
        @(posedge clk); req <= 1'b0;
      end else wreg(8'h08, {29'h0, lv});
      repeat (3) @(negedge clk);
      chk("level", pl, lv);
      chk("outs", outs, (s == 4) ? 7'h1d : 7'h07);
      wreg(8'h04, 32'h0);
      if (s != 4) begin
        @(posedge clk); pin[4] <= 1'b1;
        repeat (8) @(negedge clk);
        chk("ss_receive_pair_off", pl, lv);
        @(posedge clk); pin[4] <= 1'b0;
      end
      @(posedge clk); pin[s] <= ~pin[s];
      wait_pl(lpwc_pkg::LVL_RESTART, 10);
      chk("pll_on", pen, 1'b1);
      repeat (2400) @(negedge clk);
      chk("settling", pl, 3'h7);
      wait_pl(lpwc_pkg::LVL_NORMAL, 300);
      repeat (3) @(negedge clk);
      chk("no_pc_reset", crn, 1'b1);
      rreg(8'h18, 32'h1 << s, "cause");
      @(posedge clk); pin[s] <= ~pin[s];
      repeat (4) @(posedge clk);
      wreg(8'h18, 32'h1ff);
    end
    rreg(8'h04, 32'h7f, "retained");
    rreg(8'h0c, 32'h2, "mailbox");
    wreg(8'h10, 32'h0);
    wreg(8'h00, 32'h05);
    wait_on(irq, 1'b1, 800);
    chk("irq", irq, 1'b1);
    rreg(8'h18, 32'h100, "wd_exp");
    wreg(8'h00, 32'h04);
    wreg(8'h18, 32'h1ff);
    repeat (1600) @(negedge clk);
    chk("wd_off", irq, 1'b0);
    rreg(8'h18, 32'h0, "wd_off_stat");
    wreg(8'h00, 32'h07);
    wait_on(irq, 1'b1, 100);
    chk("ext_clk", irq, 1'b1);
    wreg(8'h00, 32'h11);
    wait_on(crn, 1'b0, 800);
    chk("wd_reset", crn, 1'b0);
    wreg(8'h00, 32'h09);
    wreg(8'h08, 32'h3);
    wait_pl(lpwc_pkg::LVL_RESTART, 800);
    wait_pl(lpwc_pkg::LVL_NORMAL, 2600);
    wait_on(crn, 1'b0, 5);
    chk("standby_reset", crn, 1'b0);
    // Clear-to-send idles high, so a high active polarity wakes standby at once.
    wreg(8'h00, 32'h20);
    wreg(8'h08, 32'h3);
    wait_pl(lpwc_pkg::LVL_RESTART, 10);
    wait_pl(lpwc_pkg::LVL_NORMAL, 2600);
    rreg(8'h18, 32'h120, "cts_pol");
    close_out();
  end
endmodule
